// file: design/fams_pkg.sv
// Contract
// R01 - all lines low means standby, no access
// R02 - read encoding enables rows, columns, amps, drive
// R03 - row_enable low disables every row
// R04 - column_enable low disconnects the column selector
// R05 - data_drive_enable low floats read data
// R06 - word program encoding, write_pulse defines cycle
// R07 - page erase encoding, pulse at least 20 ms
// R08 - mass erase adds whole_block_select, 100 ms
// R09 - store_strobe marks the non-volatile store phase
// R10 - info_block_select picks info or main block; a mass erase with it set erases both blocks
// R11 - pulse line leads store_strobe by setup time
// R12 - store hold 5/100 us, then 1 us recovery
// R13 - 10 us program setup, pulse at least 20 us
// R14 - summed program time per row below 3 ms; code refuses only a sum above 3 ms, so exactly 3 ms passes
// R15 - never program an address twice before erase
// R16 - manual intervals only in manual word mode
// R17 - programmable setting for every timed interval
// R18 - count clocks, rounding intervals up
// R19 - return to standby after recovery
package fams_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 16;
  localparam int WORDS      = 4096;
  localparam int ROW_W      = 6;
  localparam int ROWS       = 64;
  localparam int ROW_LSB    = 6;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ        = 50;
  localparam int T_NVS_US       = 5;
  localparam int T_NVH_US       = 5;
  localparam int T_NVH1_US      = 100;
  localparam int T_PGS_US       = 10;
  localparam int T_REV_US       = 1;
  localparam int T_WRITE_PULSE_US      = 20;
  localparam int T_ERASE_MS     = 20;
  localparam int T_ME_MS        = 100;
  localparam int T_HV_MS        = 3;
  localparam int CNT_W          = 24;
  localparam logic [CNT_W-1:0] CYC_NVS   = CNT_W'(T_NVS_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_NVH   = CNT_W'(T_NVH_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_NVH1  = CNT_W'(T_NVH1_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_PGS   = CNT_W'(T_PGS_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_REV   = CNT_W'(T_REV_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_WRITE_PULSE  = CNT_W'(T_WRITE_PULSE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_ERASE = CNT_W'(T_ERASE_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_ME    = CNT_W'(T_ME_MS * 1000 * CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC_HV    = CNT_W'(T_HV_MS * 1000 * CLK_MHZ);

  // ****************************************************************
  // register map of the controller (byte addresses, one 32-bit register every 4)
  // ****************************************************************
  localparam logic [5:0] REG_CMD    = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_ADDR   = 6'h08;
  localparam logic [5:0] REG_WDATA  = 6'h0C;
  localparam logic [5:0] REG_RDATA  = 6'h10;
  localparam logic [5:0] REG_NVS    = 6'h14;
  localparam logic [5:0] REG_NVH    = 6'h18;
  localparam logic [5:0] REG_NVH1   = 6'h1C;
  localparam logic [5:0] REG_PGS    = 6'h20;
  localparam logic [5:0] REG_REV    = 6'h24;
  localparam logic [5:0] REG_WRITE_PULSE   = 6'h28;
  localparam logic [5:0] REG_ERASE  = 6'h2C;
  localparam logic [5:0] REG_ME     = 6'h30;

  // command field: bits 1:0 operation, bit 2 info block select
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_INFO_BIT = 2;
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE_PULSE  = 2'h1;
  localparam logic [1:0] OP_PERA  = 2'h2;
  localparam logic [1:0] OP_MERA  = 2'h3;

  // status bits
  localparam int ST_BUSY   = 0;
  localparam int ST_REFUSE = 1;
  localparam int ST_MODERR = 2;
  localparam logic [31:0] ERASED_WORD = 32'h0000FFFF;

  // ****************************************************************
  // array operating modes
  // ****************************************************************
  typedef enum logic [4:0] {
    FAMS_STANDBY = 5'b00001,
    FAMS_READ    = 5'b00010,
    FAMS_WRITE_PULSE    = 5'b00100,
    FAMS_PERASE  = 5'b01000,
    FAMS_MERASE  = 5'b10000
  } fams_mode_t;

endpackage : fams_pkg

// file: design/fams_if.sv
`timescale 1ns/1ps
interface fams_if;
  import fams_pkg::*;
  logic              row_enable;
  logic              column_enable;
  logic              amp_on;
  logic              data_drive_enable;
  logic              write_pulse;
  logic              erase_line;
  logic              whole_block_select;
  logic              store_strobe;
  logic              info_block_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rdata_oe;

  modport array (
    input  row_enable, column_enable, amp_on, data_drive_enable, write_pulse,
           erase_line, whole_block_select, store_strobe, info_block_select, addr, wdata,
    output rdata, rdata_oe
  );
  modport ctrl (
    output row_enable, column_enable, amp_on, data_drive_enable, write_pulse,
           erase_line, whole_block_select, store_strobe, info_block_select, addr, wdata,
    input  rdata, rdata_oe
  );
endinterface : fams_if

// file: design/fams_array.sv
`timescale 1ns/1ps
module fams_array
  import fams_pkg::*;
(
  // clock and reset
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  input  wire logic   clk_en_i,
  // array pins
  fams_if.array       fl,
  // observation
  output fams_mode_t  mode_o,
  output logic        mode_err_o,
  output logic        store_phase_o
);

  logic [DATA_W-1:0] main_mem [WORDS];
  logic [DATA_W-1:0] info_mem [WORDS];
  logic [DATA_W-1:0] rdata_q;
  fams_mode_t        mode;
  logic              err;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  always_comb
  begin
    mode = FAMS_STANDBY;
    err  = 1'b0;
    case ({fl.row_enable, fl.column_enable, fl.amp_on, fl.data_drive_enable,
           fl.write_pulse, fl.erase_line, fl.whole_block_select, fl.store_strobe})
      8'h00: mode = FAMS_STANDBY; // see R01
      8'hF0: mode = FAMS_READ;    // see R02
      8'hC9: mode = FAMS_WRITE_PULSE;    // see R06
      8'h88: mode = FAMS_STANDBY; // program lead before the strobe
      8'h89: mode = FAMS_STANDBY; // program set-up: strobe up, column not yet
      8'h85: mode = FAMS_PERASE;  // see R07
      8'h87: mode = FAMS_MERASE;  // see R08
      8'h84, 8'h86, 8'h81, 8'h83, 8'h80, 8'hC0: mode = FAMS_STANDBY;
      default: err = 1'b1;
    endcase
  end

  assign mode_o        = mode;
  assign mode_err_o    = err;
  assign store_phase_o = fl.store_strobe; // see R09

  // ****************************************************************
  // array contents
  // ****************************************************************
  // every program cycle ANDs the word in again, so a long pulse is harmless
  always_ff @(posedge clock_i)
  begin
    if (clk_en_i)
    begin
      if (mode == FAMS_WRITE_PULSE && fl.info_block_select) // see R10
        info_mem[fl.addr] <= info_mem[fl.addr] & fl.wdata;
      else if (mode == FAMS_WRITE_PULSE)
        main_mem[fl.addr] <= main_mem[fl.addr] & fl.wdata;
      else if (mode == FAMS_PERASE || mode == FAMS_MERASE)
      begin
        for (int i = 0; i < WORDS; i++)
        begin
          if (mode == FAMS_MERASE || i[ADDR_W-1:ROW_LSB] == fl.addr[ADDR_W-1:ROW_LSB])
          begin
            if (fl.info_block_select) // see R10
              info_mem[i] <= ERASED_WORD[DATA_W-1:0];
            if (!fl.info_block_select || mode == FAMS_MERASE)
              main_mem[i] <= ERASED_WORD[DATA_W-1:0];
          end
        end
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // rows and columns both gate the read; with no row or column the last word read is held
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= '0;
    else if (clk_en_i && mode == FAMS_READ && fl.row_enable && fl.column_enable) // see R03 R04
      rdata_q <= fl.info_block_select ? info_mem[fl.addr] : main_mem[fl.addr];
  end

  assign fl.rdata    = fl.data_drive_enable ? rdata_q : '0;
  assign fl.rdata_oe = fl.data_drive_enable; // see R05

endmodule : fams_array

// file: design/fams_ctrl.sv
`timescale 1ns/1ps
module fams_ctrl
  import fams_pkg::*;
(
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          rst_b_i,
  input  wire logic          clk_en_i,
  // avalon-mm slave
  input  wire logic [5:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // array pins
  fams_if.ctrl               fl
);
  typedef enum logic [7:0] {
    FAMS_IDLE   = 8'b00000001,
    FAMS_RD     = 8'b00000010,
    FAMS_NVS    = 8'b00000100,
    FAMS_PGS    = 8'b00001000,
    FAMS_PULSE  = 8'b00010000,
    FAMS_NVH    = 8'b00100000,
    FAMS_REV    = 8'b01000000,
    FAMS_RDDONE = 8'b10000000
  } fams_st_t;
  fams_st_t          st;
  logic [CNT_W-1:0]  cnt, set_nvs, set_nvh, set_nvh1, set_pgs, set_rev;
  logic [CNT_W-1:0]  set_write_pulse, set_erase, set_me;
  logic [1:0]        op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [CNT_W-1:0]  hv_used [ROWS];
  logic [WORDS-1:0]  written;
  logic              info, refuse, busy, bus_wr, cmd_go, rd_ack;
  logic [ROW_W-1:0]  row;
  assign busy   = (st != FAMS_IDLE);
  assign row    = addr[ADDR_W-1:ROW_LSB];
  assign bus_wr = avs_write_i && clk_en_i;
  assign cmd_go = bus_wr && avs_address_i == REG_CMD && !busy;
  // reads take two cycles so the registered data stands when waitrequest drops
  assign avs_waitrequest_o = !clk_en_i || (avs_read_i && !rd_ack);
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_ack <= 1'b0;
    else if (clk_en_i)
      rd_ack <= avs_read_i && !rd_ack;
  end

  // ****************************************************************
  // interval settings
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      set_nvs   <= CYC_NVS;
      set_nvh   <= CYC_NVH;
      set_nvh1  <= CYC_NVH1;
      set_pgs   <= CYC_PGS;
      set_rev   <= CYC_REV;
      set_write_pulse  <= CYC_WRITE_PULSE;
      set_erase <= CYC_ERASE;
      set_me    <= CYC_ME;
    end
    else if (bus_wr) // see R17
    begin
      if (avs_address_i == REG_NVS)
        set_nvs <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_NVH)
        set_nvh <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_NVH1)
        set_nvh1 <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_PGS)
        set_pgs <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_REV)
        set_rev <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_WRITE_PULSE)
        set_write_pulse <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_ERASE)
        set_erase <= avs_writedata_i[CNT_W-1:0];
      else if (avs_address_i == REG_ME)
        set_me <= avs_writedata_i[CNT_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr  <= '0;
      wdata <= '0;
    end
    else if (bus_wr && !busy)
    begin
      if (avs_address_i == REG_ADDR)
        addr <= avs_writedata_i[ADDR_W-1:0];
      else if (avs_address_i == REG_WDATA)
        wdata <= avs_writedata_i[DATA_W-1:0];
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      avs_readdata_o <= '0;
    else if (clk_en_i && avs_read_i && !rd_ack)
    begin
      if (avs_address_i == REG_CMD)
        avs_readdata_o <= {29'h0, info, op};
      else if (avs_address_i == REG_STATUS)
        avs_readdata_o <= {29'h0, 1'b0, refuse, busy};
      else if (avs_address_i == REG_ADDR)
        avs_readdata_o <= {20'h0, addr};
      else if (avs_address_i == REG_WDATA)
        avs_readdata_o <= {16'h0, wdata};
      else if (avs_address_i == REG_RDATA)
        avs_readdata_o <= {16'h0, rdata};
      else if (avs_address_i == REG_NVS)
        avs_readdata_o <= {8'h0, set_nvs};
      else if (avs_address_i == REG_NVH)
        avs_readdata_o <= {8'h0, set_nvh};
      else if (avs_address_i == REG_NVH1)
        avs_readdata_o <= {8'h0, set_nvh1};
      else if (avs_address_i == REG_PGS)
        avs_readdata_o <= {8'h0, set_pgs};
      else if (avs_address_i == REG_REV)
        avs_readdata_o <= {8'h0, set_rev};
      else if (avs_address_i == REG_WRITE_PULSE)
        avs_readdata_o <= {8'h0, set_write_pulse};
      else if (avs_address_i == REG_ERASE)
        avs_readdata_o <= {8'h0, set_erase};
      else if (avs_address_i == REG_ME)
        avs_readdata_o <= {8'h0, set_me};
      else
        avs_readdata_o <= '0;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st     <= FAMS_IDLE;
      cnt    <= '0;
      op     <= OP_READ;
      info   <= 1'b0;
      refuse <= 1'b0;
      rdata  <= '0;
    end
    else if (clk_en_i)
    begin
      if (cnt != '0)
        cnt <= cnt - 1'b1; // see R18
      case (st)
        FAMS_IDLE:
          if (cmd_go)
          begin
            op     <= avs_writedata_i[CMD_OP_LSB +: 2];
            info   <= avs_writedata_i[CMD_INFO_BIT];
            refuse <= 1'b0;
            if (avs_writedata_i[CMD_OP_LSB +: 2] == OP_READ)
              st <= FAMS_RD;
            else if (avs_writedata_i[CMD_OP_LSB +: 2] == OP_WRITE_PULSE
                     && (written[addr] || hv_used[row] + set_write_pulse > CYC_HV)) // see R14 R15
              refuse <= 1'b1;
            else
            begin
              st  <= FAMS_NVS;
              cnt <= set_nvs; // see R11 R16
            end
          end
        FAMS_RD:
          st <= FAMS_RDDONE;
        FAMS_RDDONE:
        begin
          rdata <= fl.rdata;
          st    <= FAMS_IDLE; // see R19
        end
        FAMS_NVS:
          if (cnt == '0)
          begin
            st  <= (op == OP_WRITE_PULSE) ? FAMS_PGS : FAMS_PULSE;
            cnt <= (op == OP_WRITE_PULSE) ? set_pgs :
                   (op == OP_MERA) ? set_me : set_erase; // see R07 R08 R13
          end
        FAMS_PGS:
          if (cnt == '0)
          begin
            st  <= FAMS_PULSE;
            cnt <= set_write_pulse; // see R13
          end
        FAMS_PULSE:
          if (cnt == '0)
          begin
            st  <= FAMS_NVH;
            cnt <= (op == OP_MERA) ? set_nvh1 : set_nvh; // see R12
          end
        FAMS_NVH:
          if (cnt == '0)
          begin
            st  <= FAMS_REV;
            cnt <= set_rev; // see R12
          end
        FAMS_REV:
          if (cnt == '0)
            st <= FAMS_IDLE; // see R19
        default:
          st <= FAMS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // wear bookkeeping
  // ****************************************************************
  // tracking sized for the main block only; an erase clears its rows in both tables, a mass erase clears all
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      written <= '0;
      for (int i = 0; i < ROWS; i++)
        hv_used[i] <= '0;
    end
    else if (clk_en_i && st == FAMS_NVS && cnt == '0)
    begin
      if (op == OP_WRITE_PULSE)
      begin
        written[addr] <= 1'b1; // see R15
        hv_used[row]  <= hv_used[row] + set_write_pulse; // see R14
      end
      else
      begin
        for (int i = 0; i < WORDS; i++)
          if (op == OP_MERA || i[ADDR_W-1:ROW_LSB] == row)
            written[i] <= 1'b0;
        for (int i = 0; i < ROWS; i++)
          if (op == OP_MERA || i[ROW_W-1:0] == row)
            hv_used[i] <= '0;
      end
    end
  end

  // ****************************************************************
  // array pins from state
  // ****************************************************************
  always_comb
  begin
    fl.row_enable         = (st != FAMS_IDLE) && (st != FAMS_REV);
    fl.column_enable      = (st == FAMS_RD || st == FAMS_RDDONE) ||
                            (op == OP_WRITE_PULSE && st == FAMS_PULSE); // see R13
    fl.amp_on             = (st == FAMS_RD || st == FAMS_RDDONE); // see R02
    fl.data_drive_enable  = fl.amp_on;
    fl.write_pulse        = (op == OP_WRITE_PULSE) &&
                            (st == FAMS_NVS || st == FAMS_PGS || st == FAMS_PULSE); // see R06
    fl.erase_line         = (op != OP_WRITE_PULSE) && (st == FAMS_NVS || st == FAMS_PULSE);
    fl.whole_block_select = (op == OP_MERA) && fl.erase_line; // see R08
    fl.store_strobe       = (st == FAMS_PGS || st == FAMS_PULSE || st == FAMS_NVH); // see R09
    fl.info_block_select  = info; // see R10
    fl.addr               = addr;
    fl.wdata              = wdata;
  end
endmodule : fams_ctrl

// file: verif/fams_checker.sv
`timescale 1ns/1ps
module fams_checker
  import fams_pkg::*;
#(
  parameter int ER_CYC = 20,
  parameter int ME_CYC = 30
)
(
  // clock and reset
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  // array lines
  input wire logic              row_enable,
  input wire logic              column_enable,
  input wire logic              amp_on,
  input wire logic              data_drive_enable,
  input wire logic              write_pulse,
  input wire logic              erase_line,
  input wire logic              whole_block_select,
  input wire logic              store_strobe,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rdata_oe
);
  // ****************************************
  // helper logic
  // ****************************************
  logic       pulse_any;
  logic [7:0] er_cnt;
  logic       me_q;

  assign pulse_any = write_pulse | erase_line;

  // counts only strobed erase cycles, so the set-up lead is not credited
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
      er_cnt <= 8'h00;
    else if (!erase_line)
      er_cnt <= 8'h00;
    else if (store_strobe)
      er_cnt <= er_cnt + 8'h01;

  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i)
      me_q <= 1'b0;
    else
      me_q <= erase_line & whole_block_select;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence all_low;
    !(row_enable | column_enable | amp_on | data_drive_enable | pulse_any
      | whole_block_select | store_strobe);
  endsequence
  sequence lead_held;
    $past(pulse_any, 1) && $past(pulse_any, 4);
  endsequence
  property setup_p;
    $rose(store_strobe) |-> lead_held;
  endproperty

  read_enc_a: assert property (data_drive_enable |-> row_enable && column_enable && amp_on
    && !(pulse_any || whole_block_select || store_strobe)) else $error("bad read encoding");
  float_out_a: assert property (!data_drive_enable |-> !rdata_oe && rdata == '0)
    else $error("read data driven while output disabled");
  write_pulse_enc_a: assert property (write_pulse |-> row_enable && !amp_on && !data_drive_enable
    && !erase_line && !whole_block_select && (!column_enable || store_strobe))
    else $error("bad program lines");
  pgs_wait_a: assert property (write_pulse && $rose(column_enable)
    |-> $past(store_strobe, 1) && $past(store_strobe, 4))
    else $error("program pulse before set-up");
  erase_enc_a: assert property (erase_line |-> row_enable && !column_enable && !amp_on
    && !data_drive_enable && !write_pulse) else $error("bad erase lines");
  mass_enc_a: assert property (whole_block_select |-> !column_enable && !write_pulse
    && !amp_on) else $error("bad mass erase lines");
  col_row_a: assert property (column_enable |-> row_enable)
    else $error("column path without row");
  strobe_ctx_a: assert property (store_strobe |-> !amp_on && !data_drive_enable)
    else $error("sensing during store phase");
  store_setup_a: assert property (setup_p)
    else $error("store strobe without pulse lead");
  store_hold_a: assert property ($fell(pulse_any) |-> store_strobe [*4])
    else $error("store strobe dropped early");
  recovery_a: assert property ($fell(store_strobe) |-> all_low [*3])
    else $error("lines not idle in recovery");
  erase_len_a: assert property ($fell(erase_line) |-> er_cnt >= (me_q ? ME_CYC : ER_CYC))
    else $error("erase pulse too short");
endmodule : fams_checker

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench
  import fams_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic        clock_i;
  logic        rst_b_i = 1'b0;
  logic        en = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  fams_mode_t  mode;
  logic        mode_err;
  logic        store_phase;
  logic [4:0]  seen = 5'h00;
  logic [31:0] r;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  localparam logic [CNT_W-1:0] DFLT [8] = '{CYC_NVS, CYC_NVH, CYC_NVH1, CYC_PGS,
                                            CYC_REV, CYC_WRITE_PULSE, CYC_ERASE, CYC_ME};
  // short intervals keep erase runs to tens of cycles
  localparam logic [CNT_W-1:0] SHORT [8] = '{24'h4, 24'h5, 24'h6, 24'h4,
                                             24'h4, 24'h6, 24'h14, 24'h1E};
  localparam logic [11:0] A = 12'h045;
  localparam logic [11:0] B = 12'h085;
  localparam logic [11:0] C = 12'h0C1;

  fams_if fl ();
  fams_ctrl fams_ctrl_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(en),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .fl(fl));
  fams_array fams_array_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(en), .fl(fl),
    .mode_o(mode), .mode_err_o(mode_err), .store_phase_o(store_phase));
  fams_checker #(.ER_CYC(int'(SHORT[6])), .ME_CYC(int'(SHORT[7]))) fams_checker_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .row_enable(fl.row_enable),
    .column_enable(fl.column_enable), .amp_on(fl.amp_on),
    .data_drive_enable(fl.data_drive_enable), .write_pulse(fl.write_pulse),
    .erase_line(fl.erase_line), .whole_block_select(fl.whole_block_select),
    .store_strobe(fl.store_strobe), .rdata(fl.rdata), .rdata_oe(fl.rdata_oe));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // read data is taken at the edge that sees waitrequest low
  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clock_i);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic do_op(input logic [1:0] op, input logic info, input logic [11:0] a,
                       input logic [15:0] d, output logic [31:0] st);
    st = '1;
    bus_wr(REG_ADDR, 32'(a));
    bus_wr(REG_WDATA, 32'(d));
    bus_wr(REG_CMD, 32'({info, op}));
    while (st[ST_BUSY] !== 1'b0)
      bus_rd(REG_STATUS, st);
  endtask : do_op

  task automatic rd_word(input logic info, input logic [11:0] a, output logic [31:0] d);
    logic [31:0] st;
    do_op(OP_READ, info, a, 16'h0000, st);
    bus_rd(REG_RDATA, d);
  endtask : rd_word

  task automatic tally_and_finish;
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // monitors
  // ****************************************
  always @(negedge clock_i)
    if (rst_b_i)
    begin
      seen |= mode;
      if (mode_err !== 1'b0 || store_phase !== fl.store_strobe)
      begin
        $display("ERROR mode flags expected 0 %b seen %b %b", fl.store_strobe, mode_err,
                 store_phase);
        num_errors++;
      end
    end

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus_rd(REG_NVS + 6'(4 * i), r);
      chk("interval default", 32'(DFLT[i]), r);
      bus_wr(REG_NVS + 6'(4 * i), 32'(SHORT[i]));
      bus_rd(REG_NVS + 6'(4 * i), r);
      chk("interval setting", 32'(SHORT[i]), r);
    end
    bus_rd(REG_STATUS, r);
    chk("status idle", 32'h0, r);
    bus_rd(6'h3C, r);
    chk("unmapped read", 32'h0, r);
    en <= 1'b0;
    fork
      bus_wr(REG_ADDR, 32'h0000_0ABC);
      begin
        repeat (3) @(posedge clock_i);
        chk("waitrequest", 32'h1, 32'(avs_waitrequest));
        en <= 1'b1;
      end
    join
    bus_rd(REG_ADDR, r);
    chk("address after stall", 32'h0000_0ABC, r);
    do_op(OP_MERA, 1'b1, A, 16'h0000, r);
    rd_word(1'b1, C, r);
    chk("info erased", ERASED_WORD, r);
    rd_word(1'b0, A, r);
    chk("main erased", ERASED_WORD, r);
    do_op(OP_WRITE_PULSE, 1'b0, A, 16'h1234, r);
    chk("program status", 32'h0, r);
    do_op(OP_WRITE_PULSE, 1'b0, B, 16'h5A0F, r);
    do_op(OP_WRITE_PULSE, 1'b1, C, 16'h0F0F, r);
    rd_word(1'b0, A, r);
    chk("word A", 32'h0000_1234, r);
    rd_word(1'b0, B, r);
    chk("word B", 32'h0000_5A0F, r);
    rd_word(1'b0, C, r);
    chk("main C untouched", ERASED_WORD, r);
    rd_word(1'b1, C, r);
    chk("info C", 32'h0000_0F0F, r);
    do_op(OP_WRITE_PULSE, 1'b0, A, 16'h0000, r);
    chk("second program refused", 32'h2, r);
    rd_word(1'b0, A, r);
    chk("word A kept", 32'h0000_1234, r);
    do_op(OP_PERA, 1'b0, A, 16'h0000, r);
    rd_word(1'b0, A, r);
    chk("page erased", ERASED_WORD, r);
    rd_word(1'b0, B, r);
    chk("other row kept", 32'h0000_5A0F, r);
    do_op(OP_WRITE_PULSE, 1'b0, A, 16'h00C3, r);
    chk("program after erase", 32'h0, r);
    rd_word(1'b0, A, r);
    chk("word A again", 32'h0000_00C3, r);
    chk("modes seen", 32'h1F, 32'(seen));
    tally_and_finish();
  end
endmodule : testbench
